// ### logic/sed_defines.svh
`ifndef SED_DEFINES_SVH
`define SED_DEFINES_SVH

// Device type codes in the top nibble of the address byte.
`define SED_TYPE_MAIN  4'hA
`define SED_TYPE_SEC   4'hB
// Top two word address bits that select the security region.
`define SED_SEC_SEL    2'b10
// Direction bit value for a read.
`define SED_RD_DIR     1'b1
// Address masks for the two capacity variants.
`define SED_MASK_SMALL 8'h7F
`define SED_MASK_LARGE 8'hFF
// Storage sizes in bytes, and the serial number size in bits.
`define SED_MAIN_DEPTH 256
`define SED_SEC_DEPTH  32
`define SED_SER_BYTES  16
`define SED_SER_BITS   128
// Value of an unprogrammed byte, also a released data line.
`define SED_ERASED     8'hFF
// Bits in one byte on the link.
`define SED_BYTE_BITS  4'h8

`endif

// ### logic/sed_pkg.sv
package sed_pkg;

    // Link protocol states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_WA,
        ST_WA_ACK,
        ST_RD,
        ST_RD_ACK
    } sed_state_t;

    // Fetch request carried from the link side to the storage side.
    typedef struct packed {
        logic       sec;
        logic       ok;
        logic [7:0] addr;
    } sed_req_t;

endpackage : sed_pkg

// ### logic/sed_read_path.sv
`timescale 1ns/100ps
`include "sed_defines.svh"

// Summary of operation
// - Reads framed like writes; direction bit one selects read.
// - One address pointer shared by main array and security region.
// - Pointer holds last accessed location plus one between transfers.
// - Main array read wraps from last byte to first byte.
// - Matching read address is acknowledged, byte at pointer shifted out.
// - Host not acknowledging a byte ends the read; line released.
// - Dummy write acknowledged, word address loaded, then addressed read.
// - Small variant ignores the top word address bit for main array accesses.
// - Acknowledged byte advances pointer and sends next; array wraps.
// - Security region: 16 serial bytes then 16 user bytes.
// - Security reads need type 1011b and word address top bits 10b.
// - Security access without 10b select returns no valid data.
// - Security sequential read wraps from byte 31 to byte 0.
// - After a security access the pointer holds last location plus one.
module sed_read_path
    import sed_pkg::*;
#(
    parameter bit           SMALL   = 1'b0,
    // Arbitrary value.
    parameter logic [2:0]   HW_ADDR = 3'h0,
    // Arbitrary value.
    parameter logic [127:0] SERIAL  =
        128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
    // Core clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    // Storage load port, core domain
    input  wire logic       ld_en_i,
    input  wire logic       ld_sec_i,
    input  wire logic [7:0] ld_addr_i,
    input  wire logic [7:0] ld_data_i,
    // Two-wire link
    input  wire logic       link_clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o
);

////////////////////////////////////////////////////////////////////////////
// Storage, core domain.

    logic [7:0] main_mem_q [`SED_MAIN_DEPTH];
    logic [7:0] sec_mem_q  [`SED_SEC_DEPTH];
    logic [7:0] rd_data_q;
    logic       rq_s1_q;
    logic       rq_s2_q;
    logic       rq_s3_q;
    logic       ack_tgl_q;
    sed_req_t   req_q;
    logic       req_tgl_q;

    // The serial half cannot be loaded; it is fixed at reset.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < `SED_MAIN_DEPTH; i++) begin
                main_mem_q[i] <= `SED_ERASED;
            end
            for (int i = 0; i < `SED_SER_BYTES; i++) begin
                sec_mem_q[i] <= SERIAL[`SED_SER_BITS-1-8*i -: 8];
            end
            for (int i = `SED_SER_BYTES; i < `SED_SEC_DEPTH; i++) begin
                sec_mem_q[i] <= `SED_ERASED;
            end
        end else if (ld_en_i) begin
            if (!ld_sec_i) begin
                main_mem_q[ld_addr_i] <= ld_data_i;
            end else if (ld_addr_i[4]) begin
                sec_mem_q[ld_addr_i[4:0]] <= ld_data_i;
            end
        end
    end

    // Request toggle crossing into the core domain.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
        end else begin
            rq_s1_q <= req_tgl_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
        end
    end

    // The request word is stable for the whole crossing, so it is read
    // directly once the toggle has been synchronised.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_q <= `SED_ERASED;
            ack_tgl_q <= 1'b0;
        end else if (rq_s2_q != rq_s3_q) begin
            ack_tgl_q <= ~ack_tgl_q;
            if (!req_q.ok) begin
                rd_data_q <= `SED_ERASED;
            end else if (req_q.sec) begin
                rd_data_q <= sec_mem_q[req_q.addr[4:0]];
            end else begin
                rd_data_q <= main_mem_q[req_q.addr];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////
// Link pin synchronisers and bus events, link domain.

    logic       scl_s1_q;
    logic       scl_s2_q;
    logic       scl_q;
    logic       sda_s1_q;
    logic       sda_s2_q;
    logic       sda_q;
    logic       ak_s1_q;
    logic       ak_s2_q;
    logic       ak_s3_q;
    logic [7:0] fetched_q;

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_q    <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_q    <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_q    <= sda_s2_q;
        end
    end

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ak_s1_q   <= 1'b0;
            ak_s2_q   <= 1'b0;
            ak_s3_q   <= 1'b0;
            fetched_q <= `SED_ERASED;
        end else begin
            ak_s1_q <= ack_tgl_q;
            ak_s2_q <= ak_s1_q;
            ak_s3_q <= ak_s2_q;
            if (ak_s2_q != ak_s3_q) begin
                fetched_q <= rd_data_q;
            end
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s2_q & ~scl_q;
    assign scl_fall  = ~scl_s2_q & scl_q;
    assign bus_start = scl_s2_q & scl_q & sda_q & ~sda_s2_q;
    assign bus_stop  = scl_s2_q & scl_q & ~sda_q & sda_s2_q;

////////////////////////////////////////////////////////////////////////////
// Decode, link domain.

    sed_state_t state_q;
    logic [3:0] bits_q;
    logic [7:0] shreg_q;
    logic [7:0] ptr_q;
    logic       rd_sec_q;
    logic       rd_ok_q;
    logic       sec_ok_q;
    logic       rw_q;
    logic       ack_q;
    logic       drive_q;

    logic [7:0] addr_mask;
    logic       byte_end;
    logic       dev_hit;
    logic       dev_sec;
    logic       start_read;
    logic       rd_byte_end;
    logic       wa_load;
    logic       wa_sec_ok;
    logic [7:0] ptr_next;

    assign addr_mask   = SMALL ? `SED_MASK_SMALL : `SED_MASK_LARGE;
    assign byte_end    = scl_fall && (bits_q == `SED_BYTE_BITS);
    assign dev_sec     = (shreg_q[7:4] == `SED_TYPE_SEC);
    assign dev_hit     = ((shreg_q[7:4] == `SED_TYPE_MAIN) || dev_sec)
                         && (shreg_q[3:1] == HW_ADDR);
    assign start_read  = (state_q == ST_DEV) && byte_end && dev_hit
                         && (shreg_q[0] == `SED_RD_DIR);
    assign rd_byte_end = (state_q == ST_RD) && byte_end;
    assign wa_load     = (state_q == ST_WA) && byte_end;
    assign wa_sec_ok   = rd_sec_q && (shreg_q[7:6] == `SED_SEC_SEL);

    // Security reads wrap inside 32 bytes, main reads over the array.
    always_comb begin
        if (rd_sec_q) begin
            ptr_next = {3'h0, ptr_q[4:0] + 5'h01};
        end else begin
            ptr_next = (ptr_q + 8'h01) & addr_mask;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Shared address pointer and region.

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_q <= 8'h00;
        end else if (wa_load && !rd_sec_q) begin
            ptr_q <= shreg_q & addr_mask;
        end else if (wa_load && wa_sec_ok) begin
            ptr_q <= {3'h0, shreg_q[4:0]};
        end else if (rd_byte_end) begin
            ptr_q <= ptr_next;
        end
    end

    // A failed select is remembered until the next word address, so
    // a current address read of the region also yields no valid data.
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_sec_q <= 1'b0;
            rd_ok_q  <= 1'b1;
            sec_ok_q <= 1'b0;
        end else begin
            if ((state_q == ST_DEV) && byte_end && dev_hit) begin
                rd_sec_q <= dev_sec;
            end
            if (wa_load) begin
                sec_ok_q <= wa_sec_ok;
            end
            if (start_read) begin
                rd_ok_q <= !dev_sec || sec_ok_q;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////
// Fetch requests toward storage.

    // The fetch is launched a full acknowledge slot ahead of the first
    // bit, so the link clock must oversample the serial clock well.
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_q     <= '0;
            req_tgl_q <= 1'b0;
        end else if (start_read) begin
            req_q.sec  <= dev_sec;
            req_q.ok   <= !dev_sec || sec_ok_q;
            req_q.addr <= dev_sec ? {3'h0, ptr_q[4:0]} : ptr_q & addr_mask;
            req_tgl_q  <= ~req_tgl_q;
        end else if (rd_byte_end) begin
            req_q.sec  <= rd_sec_q;
            req_q.ok   <= rd_ok_q;
            req_q.addr <= ptr_next;
            req_tgl_q  <= ~req_tgl_q;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Link protocol engine.

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            bits_q  <= 4'h0;
            shreg_q <= 8'h00;
            rw_q    <= 1'b0;
            ack_q   <= 1'b0;
            drive_q <= 1'b0;
        end else if (bus_start) begin
            state_q <= ST_DEV;
            bits_q  <= 4'h0;
            drive_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= ST_IDLE;
            drive_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    bits_q <= 4'h0;
                end
                ST_DEV, ST_WA: begin
                    if (scl_rise && bits_q != `SED_BYTE_BITS) begin
                        shreg_q <= {shreg_q[6:0], sda_s2_q};
                        bits_q  <= bits_q + 4'h1;
                    end
                    if (byte_end && state_q == ST_WA) begin
                        drive_q <= 1'b1;
                        state_q <= ST_WA_ACK;
                    end else if (byte_end && dev_hit) begin
                        drive_q <= 1'b1;
                        rw_q    <= shreg_q[0];
                        state_q <= ST_DEV_ACK;
                    end else if (byte_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        bits_q <= 4'h0;
                        if (rw_q) begin
                            shreg_q <= fetched_q;
                            drive_q <= ~fetched_q[7];
                            state_q <= ST_RD;
                        end else begin
                            drive_q <= 1'b0;
                            state_q <= ST_WA;
                        end
                    end
                end
                ST_WA_ACK: begin
                    // Write data is not handled here; only a repeated
                    // Start continues the transfer.
                    if (scl_fall) begin
                        drive_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bits_q <= bits_q + 4'h1;
                    end
                    if (byte_end) begin
                        drive_q <= 1'b0;
                        state_q <= ST_RD_ACK;
                    end else if (scl_fall) begin
                        shreg_q <= {shreg_q[6:0], 1'b1};
                        drive_q <= ~shreg_q[6];
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        ack_q <= ~sda_s2_q;
                    end
                    if (scl_fall && ack_q) begin
                        bits_q  <= 4'h0;
                        shreg_q <= fetched_q;
                        drive_q <= ~fetched_q[7];
                        state_q <= ST_RD;
                    end else if (scl_fall) begin
                        drive_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Open-drain: the line is only ever pulled low.
    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_q;

endmodule : sed_read_path

// ### dv/sed_read_path_monitor.sv
`timescale 1ns/100ps
module sed_read_path_monitor #(
    parameter logic [2:0] HW_ADDR = 3'h0
) (
    // Link clock and reset
    input wire logic link_clk_i,
    input wire logic rstn_i,
    // Two-wire pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    logic       scl_q;
    logic       sda_q;
    logic       rd_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    logic       hit_q;
    wire start = scl_i && scl_q && sda_q && !sda_i;
    wire stop  = scl_i && scl_q && !sda_q && sda_i;
    wire rise  = scl_i && !scl_q;
    wire ninth = rise && bit_q == 4'h8;
    wire match = sh_q[7:5] == 3'b101 && sh_q[3:1] == HW_ADDR;
    wire nack  = ninth && rd_q && byte_q != 2'h0 && sda_i;

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Position inside a transfer; the ack slot is bit eight.
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
            sh_q   <= 8'h00;
            rd_q   <= 1'b0;
            hit_q  <= 1'b0;
        end else if (start) begin
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
        end else if (rise) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            sh_q  <= {sh_q[6:0], sda_i};
            if (bit_q == 4'h8 && byte_q != 2'h3)
                byte_q <= byte_q + 2'h1;
            if (bit_q == 4'h7 && byte_q == 2'h0)
                rd_q <= sda_i;
            if (bit_q == 4'h8 && byte_q == 2'h0)
                hit_q <= match;
        end
    end

    default clocking @(posedge link_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    AST_DATA_ON_LOW: assert property ($changed(sda_oe_o)
        |-> !scl_i && !$past(scl_i, 2)) else $error("drive moved, clock high");
    AST_HOLD_HIGH: assert property ($rose(scl_i)
        |-> $stable(sda_oe_o) [*8]) else $error("bit not held");
    AST_ADDR_ACK: assert property (ninth && byte_q == 2'h0
        |-> sda_oe_o == match) else $error("address ack wrong");
    AST_WA_ACK: assert property (ninth && byte_q == 2'h1 && !rd_q
        && hit_q |-> sda_oe_o) else $error("word address not acked");
    AST_NACK_RELEASE: assert property (nack |-> !sda_oe_o [*8] ##1
        !sda_oe_o [*8] ##1 !sda_oe_o [*8]) else $error("drive after nack");
    AST_STOP_IDLE: assert property (stop |-> !sda_oe_o [*8])
        else $error("drive after stop");
    AST_START_IDLE: assert property (start |-> !sda_oe_o [*8])
        else $error("drive after start");

    cover property (nack);
    cover property (ninth && byte_q == 2'h0 && !match);
    cover property (ninth && rd_q && byte_q != 2'h0 && !sda_i);
    cover property (ninth && byte_q == 2'h1 && hit_q && !rd_q);
endmodule : sed_read_path_monitor

bind sed_read_path sed_read_path_monitor #(.HW_ADDR(HW_ADDR)) u_mon (
    .link_clk_i, .rstn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o);

// ### dv/sed_host_model.sv
`timescale 1ns/100ps
module sed_host_model (
    // Wire level
    input  wire logic sda_i,
    // Host drive; high means released to the pull-up
    output logic       scl_o   = 1'b1,
    output logic       sda_o   = 1'b1,
    // Each ack or byte seen, with a toggle
    output logic [7:0] obs_o   = 8'h00,
    output logic       obs_t_o = 1'b0
);
    // Quarter bit; both clock phases stay well above the sync minimum.
    localparam int Q = 225;

    task automatic start();
        sda_o = 1'b1;
        #Q scl_o = 1'b1;
        #(2*Q) sda_o = 1'b0;
        #(2*Q) scl_o = 1'b0;
        #Q;
    endtask : start

    task automatic stop();
        sda_o = 1'b0;
        #Q scl_o = 1'b1;
        #(2*Q) sda_o = 1'b1;
        #(2*Q);
    endtask : stop

    task automatic slot(input logic b, output logic s);
        sda_o = b;
        #Q scl_o = 1'b1;
        #Q s = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask : slot

    task automatic put(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) slot(b[i], s);
        slot(1'b1, s);
        obs_o = {7'h00, ~s};
        obs_t_o = ~obs_t_o;
    endtask : put

    task automatic get(input logic nak);
        logic [7:0] b;
        logic       s;
        for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
        slot(nak, s);
        obs_o = b;
        obs_t_o = ~obs_t_o;
    endtask : get
endmodule : sed_host_model

// ### dv/sed_read_path_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module sed_read_path_tb;
    // Arbitrary serial value and client addresses.
    localparam logic [127:0] SER = 128'h1357_9BDF_2468_ACE0_0F1E_2D3C_4B5A_6978;
    localparam logic [2:0]   HW  = 3'h5;
    localparam logic [2:0]   HWS = 3'h3;
    logic       core_clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       ld_en = 1'b0;
    logic       ld_sec = 1'b0;
    logic [7:0] ld_addr = 8'h00;
    logic [7:0] ld_data = 8'h00;
    logic       scl, hsda, obs_t, sda_o, sda_oe, sda_oe_s, sec, sec_ok;
    logic [2:0] hw = HW;
    logic [7:0] msk = 8'hFF;
    logic [7:0] obs, ptr, e;
    logic [7:0] mem [256];
    logic [7:0] secm [32];
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h0000_0015;
    int         fail_count = 0;
    int         compares = 0;
    wire        sda = hsda & (~sda_oe | sda_o) & ~sda_oe_s;

    always #5 core_clk = ~core_clk;
    // The offset keeps link edges off the core clock's edges.
    always begin
        if ($time == 0) #7.3;
        #15 link_clk = ~link_clk;
    end

    sed_read_path #(.HW_ADDR(HW), .SERIAL(SER)) dut (.core_clk_i(core_clk),
        .rstn_i(rstn), .ld_en_i(ld_en), .ld_sec_i(ld_sec),
        .ld_addr_i(ld_addr), .ld_data_i(ld_data), .link_clk_i(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe));
    sed_read_path #(.SMALL(1'b1), .HW_ADDR(HWS), .SERIAL(SER)) dut_small (
        .core_clk_i(core_clk), .rstn_i(rstn), .ld_en_i(ld_en),
        .ld_sec_i(ld_sec), .ld_addr_i(ld_addr), .ld_data_i(ld_data),
        .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe_s));
    sed_host_model host (.sda_i(sda), .scl_o(scl), .sda_o(hsda),
        .obs_o(obs), .obs_t_o(obs_t));

    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs

    // An empty queue gives an unknown note, so a stray unit fails.
    always @(obs_t) if (rstn) begin
        e = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
        `CHK(obs, e)
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] b, input logic ack);
        exp_q.push_back({7'h00, ack});
        host.put(b);
    endtask : wr

    task automatic cur(input logic [3:0] ty, input int n, input logic stp);
        sec = ty == 4'hB;
        host.start();
        wr({ty, hw, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(!sec ? mem[ptr & msk] :
                            sec_ok ? secm[ptr[4:0]] : 8'hFF);
            host.get(i == n - 1);
            ptr = sec ? {ptr[7:5], ptr[4:0] + 5'h01} : (ptr + 8'h01) & msk;
        end
        if (stp) host.stop();
    endtask : cur

    task automatic rnd(input logic [3:0] ty, input logic [7:0] wa,
                       input int n);
        host.start();
        wr({ty, hw, 1'b0}, 1'b1);
        wr(wa, 1'b1);
        ptr = wa;
        sec_ok = wa[7:6] == 2'b10;
        cur(ty, n, 1'b1);
    endtask : rnd

    task automatic summarize();
        for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge core_clk);
        if (exp_q.size() != 0) fail_count++;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        `CHK(sda_oe, 1'b0)
        `CHK(sda_oe_s, 1'b0)
        for (int i = 0; i < 256; i++) begin
            mem[i] = xs();
            ld_en <= 1'b1;
            ld_addr <= i[7:0];
            ld_data <= mem[i];
            @(posedge core_clk);
        end
        // Serial bytes get inverted data; the load must be refused.
        for (int i = 0; i < 32; i++) begin
            secm[i] = i < 16 ? SER[127 - 8 * i -: 8] : xs();
            ld_sec <= 1'b1;
            ld_addr <= i[7:0];
            ld_data <= i < 16 ? ~secm[i] : secm[i];
            @(posedge core_clk);
        end
        ld_en <= 1'b0;
        #200;
        rnd(4'hA, 8'hFE, 3);
        cur(4'hA, 2, 1'b0);
        rnd(4'hB, 8'h80, 33);
        cur(4'hB, 2, 1'b1);
        rnd(4'hB, 8'h05, 1);
        rnd(4'hA, xs(), 2);
        // The small variant drops the top word address bit.
        hw = HWS;
        msk = 8'h7F;
        rnd(4'hA, 8'hFE, 3);
        hw = HW;
        msk = 8'hFF;
        host.start();
        wr({4'hA, ~HW, 1'b1}, 1'b0);
        host.start();
        wr({4'h5, HW, 1'b1}, 1'b0);
        host.stop();
        summarize();
    end
endmodule : sed_read_path_tb
